/* File: pipe_desc_defs.vh */
// descriptor constants for the adapter endpoint and pipe descriptor store
// assumes byte-wide descriptor access from a request decoder on one clock
`ifndef PIPE_DESC_DEFS_VH
`define PIPE_DESC_DEFS_VH

// descriptor selector codes
`define SEL_NOTIFY_EP 2'h0
`define SEL_WRITE_EP 2'h1
`define SEL_READ_EP 2'h2
`define SEL_PIPE 2'h3

// endpoint descriptor layout and fixed values
`define EP_LEN 8'h07
`define EP_TYPE 8'h05
`define EP_ATTR_INTR 8'h03
`define EP_ATTR_BULK 8'h02
`define EP_MPS_NOTIFY 16'h0040
`define EP_IVL_NOTIFY 8'h01
`define EP_IVL_BULK 8'h00
`define EP_OFS_LEN 5'h00
`define EP_OFS_TYPE 5'h01
`define EP_OFS_ADDR 5'h02
`define EP_OFS_ATTR 5'h03
`define EP_OFS_MPS_LO 5'h04
`define EP_OFS_MPS_HI 5'h05
`define EP_OFS_IVL 5'h06

// pipe descriptor layout and fixed values
`define PIPE_LEN 8'h1c
`define PIPE_TYPE 8'h22
`define PD_OFS_LEN 5'h00
`define PD_OFS_TYPE 5'h01
`define PD_OFS_IDX_LO 5'h02
`define PD_OFS_IDX_HI 5'h03
`define PD_OFS_REQ_LO 5'h04
`define PD_OFS_REQ_HI 5'h05
`define PD_OFS_BLK_LO 5'h06
`define PD_OFS_BLK_HI 5'h07
`define PD_OFS_MPS_LO 5'h08
`define PD_OFS_MPS_HI 5'h09
`define PD_OFS_BURST 5'h0a
`define PD_OFS_DEVINFO 5'h0b
`define PD_OFS_RATE 5'h0c
`define PD_OFS_RSVD 5'h0d
`define PD_OFS_EPADDR 5'h0e

// field limits and reset values
`define BURST_MIN 8'h01
`define BURST_MAX 8'h10
`define BURST_RST 8'h01
`define EP_NUM_MSB 3
`define EP_DIR_BIT 7
`define NUM_PIPES 4
`define PIPE_SEL_W 2

// notification kinds
`define NTF_DEVICE 0
`define NTF_STATUS 1
`define NTF_XFER 2

`endif

/* File: pipe_desc_store.v */
// endpoint descriptors and per-pipe remote_pipe descriptor store
// assumes a request decoder on i_core_clk issues one byte per request
// every output leaves a flip-flop, so answers come one cycle late
//
// Behaviour
// [R1] notification endpoint carries device, status, completion events
// [R2] notification descriptor: 7 bytes, type 5, interrupt
// [R3] notification max packet size 40h
// [R4] notification polling interval one frame unit
// [R5] bulk write/read descriptors, interval zero
// [R6] pipe descriptors served only per pipe request
// [R7] pipe descriptor length 1ch, read-only
// [R8] pipe descriptor type 22h, read-only
// [R9] pipe index is zero-based position, read-only
// [R10] request capacity reported, read-only
// [R11] block count writable only while zero
// [R12] pipe packet size limits target traffic
// [R13] burst limit kept within 1 to 16
// [R14] device info select chooses info buffer
// [R15] phy rate byte selects transmit rate
// [R16] host writes zero to reserved byte
// [R17] endpoint number, zero bits, direction handling
// [R18] bytes ascending, two-byte fields low first
`include "pipe_desc_defs.vh"

module pipe_desc_store #(
  parameter [7:0] NOTIFY_EP_ADDR = 8'h81,
  parameter [7:0] WRITE_EP_ADDR = 8'h02,
  parameter [7:0] READ_EP_ADDR = 8'h83,
  parameter [15:0] BULK_MPS = 16'h0200,
  parameter [15:0] PIPE_REQ_CAP = 16'h0004
) (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_desc_rd,
  input wire i_desc_wr,
  input wire [1:0] i_desc_sel,
  input wire [`PIPE_SEL_W-1:0] i_pipe_sel,
  input wire [4:0] i_byte_offset,
  input wire [7:0] i_wr_data,
  input wire [`PIPE_SEL_W-1:0] i_active_pipe,
  input wire i_active_is_control,
  input wire i_dev_notify,
  input wire i_status_change,
  input wire i_xfer_done,
  input wire i_notify_ack,
  output reg [7:0] o_rd_data,
  output reg o_rd_valid,
  output reg o_wr_done,
  output reg o_wr_reject,
  output reg [2:0] o_notify_pending,
  output reg [15:0] o_pkt_limit,
  output reg [7:0] o_burst_limit,
  output reg [7:0] o_devinfo_sel,
  output reg [7:0] o_phy_rate,
  output reg [3:0] o_ep_num,
  output reg o_ep_dir_in
);

  // per-pipe writable fields
  reg [15:0] blocks_ff [0:`NUM_PIPES-1];
  reg [15:0] mps_ff [0:`NUM_PIPES-1];
  reg [7:0] burst_ff [0:`NUM_PIPES-1];
  reg [7:0] devinfo_ff [0:`NUM_PIPES-1];
  reg [7:0] rate_ff [0:`NUM_PIPES-1];
  reg [3:0] epnum_ff [0:`NUM_PIPES-1];
  reg epdir_ff [0:`NUM_PIPES-1];
  // low byte of a two-byte field waits here for its high byte
  reg [7:0] lo_stage_ff;
  reg [7:0] nxt_rd_data;
  reg [15:0] ep_mps;
  reg [7:0] ep_addr;
  reg [7:0] ep_attr;
  reg [7:0] ep_ivl;
  reg wr_ok;
  reg [15:0] wr_word;
  reg [15:0] pipe_idx;
  reg [2:0] ntf_events;
  integer k;
  integer j;
  // per-field write strobes, decoded once for all pipes
  reg wr_stage;
  reg wr_blocks;
  reg wr_mps;
  reg wr_burst;
  reg wr_devinfo;
  reg wr_rate;
  reg wr_epaddr;

  // pick the fixed endpoint descriptor being read
  always @* begin
    case (i_desc_sel)
      // [R2] interrupt notification endpoint
      `SEL_NOTIFY_EP: begin
        ep_addr = NOTIFY_EP_ADDR;
        ep_attr = `EP_ATTR_INTR;
        // [R3] notification packet size
        ep_mps = `EP_MPS_NOTIFY;
        // [R4] one frame or microframe
        ep_ivl = `EP_IVL_NOTIFY;
      end
      // [R5] bulk write endpoint
      `SEL_WRITE_EP: begin
        ep_addr = WRITE_EP_ADDR;
        ep_attr = `EP_ATTR_BULK;
        ep_mps = BULK_MPS;
        ep_ivl = `EP_IVL_BULK;
      end
      // [R5] bulk read endpoint
      default: begin
        ep_addr = READ_EP_ADDR;
        ep_attr = `EP_ATTR_BULK;
        ep_mps = BULK_MPS;
        ep_ivl = `EP_IVL_BULK;
      end
    endcase
  end

  // read byte mux; bytes past a descriptor's end read zero
  always @* begin
    pipe_idx = {{(16-`PIPE_SEL_W){1'b0}}, i_pipe_sel};
    nxt_rd_data = 8'h00;
    if (i_desc_sel != `SEL_PIPE) begin
      case (i_byte_offset)
        `EP_OFS_LEN: nxt_rd_data = `EP_LEN;
        `EP_OFS_TYPE: nxt_rd_data = `EP_TYPE;
        `EP_OFS_ADDR: nxt_rd_data = ep_addr;
        `EP_OFS_ATTR: nxt_rd_data = ep_attr;
        // [R18] low byte first
        `EP_OFS_MPS_LO: nxt_rd_data = ep_mps[7:0];
        `EP_OFS_MPS_HI: nxt_rd_data = ep_mps[15:8];
        `EP_OFS_IVL: nxt_rd_data = ep_ivl;
        default: nxt_rd_data = 8'h00;
      endcase
    end else begin
      // [R6] one pipe per request
      case (i_byte_offset)
        // [R7] fixed length
        `PD_OFS_LEN: nxt_rd_data = `PIPE_LEN;
        // [R8] fixed type
        `PD_OFS_TYPE: nxt_rd_data = `PIPE_TYPE;
        // [R9] zero-based pipe index
        `PD_OFS_IDX_LO: nxt_rd_data = pipe_idx[7:0];
        `PD_OFS_IDX_HI: nxt_rd_data = pipe_idx[15:8];
        // [R10] request capacity
        `PD_OFS_REQ_LO: nxt_rd_data = PIPE_REQ_CAP[7:0];
        `PD_OFS_REQ_HI: nxt_rd_data = PIPE_REQ_CAP[15:8];
        // [R18] two-byte fields low byte first
        `PD_OFS_BLK_LO: nxt_rd_data = blocks_ff[i_pipe_sel][7:0];
        `PD_OFS_BLK_HI: nxt_rd_data = blocks_ff[i_pipe_sel][15:8];
        `PD_OFS_MPS_LO: nxt_rd_data = mps_ff[i_pipe_sel][7:0];
        `PD_OFS_MPS_HI: nxt_rd_data = mps_ff[i_pipe_sel][15:8];
        `PD_OFS_BURST: nxt_rd_data = burst_ff[i_pipe_sel];
        `PD_OFS_DEVINFO: nxt_rd_data = devinfo_ff[i_pipe_sel];
        `PD_OFS_RATE: nxt_rd_data = rate_ff[i_pipe_sel];
        `PD_OFS_RSVD: nxt_rd_data = 8'h00;
        // [R17] bits 6:4 always read zero
        `PD_OFS_EPADDR: nxt_rd_data = {epdir_ff[i_pipe_sel], 3'h0,
                                       epnum_ff[i_pipe_sel]};
        default: nxt_rd_data = 8'h00;
      endcase
    end
  end

  // write acceptance; read-only bytes and bad values are refused
  always @* begin
    wr_word = {i_wr_data, lo_stage_ff};
    wr_ok = 1'b0;
    if (i_desc_sel == `SEL_PIPE) begin
      case (i_byte_offset)
        // low bytes only stage, checked with the high byte
        `PD_OFS_BLK_LO: wr_ok = 1'b1;
        // [R11] locked once nonzero
        `PD_OFS_BLK_HI: wr_ok = (blocks_ff[i_pipe_sel] == 16'h0000);
        `PD_OFS_MPS_LO: wr_ok = 1'b1;
        `PD_OFS_MPS_HI: wr_ok = 1'b1;
        // [R13] burst range check
        `PD_OFS_BURST: wr_ok = (i_wr_data >= `BURST_MIN) &&
                               (i_wr_data <= `BURST_MAX);
        `PD_OFS_DEVINFO: wr_ok = 1'b1;
        `PD_OFS_RATE: wr_ok = 1'b1;
        // [R16] reserved byte takes only zero
        `PD_OFS_RSVD: wr_ok = (i_wr_data == 8'h00);
        `PD_OFS_EPADDR: wr_ok = 1'b1;
        // [R7] length, type, index, capacity refuse writes
        default: wr_ok = 1'b0;
      endcase
    end
  end

  // read answer one cycle after the request
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_rd_data <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_desc_rd;
      if (i_desc_rd) begin
        o_rd_data <= nxt_rd_data;
      end
    end
  end

  // one strobe per stored field; a refused write raises none
  always @* begin
    wr_stage = 1'b0;
    wr_blocks = 1'b0;
    wr_mps = 1'b0;
    wr_burst = 1'b0;
    wr_devinfo = 1'b0;
    wr_rate = 1'b0;
    wr_epaddr = 1'b0;
    if (i_desc_wr && wr_ok) begin
      case (i_byte_offset)
        // low bytes wait in the stage for their high byte
        `PD_OFS_BLK_LO: wr_stage = 1'b1;
        `PD_OFS_MPS_LO: wr_stage = 1'b1;
        // [R11] high byte carries the lock result
        `PD_OFS_BLK_HI: wr_blocks = 1'b1;
        `PD_OFS_MPS_HI: wr_mps = 1'b1;
        `PD_OFS_BURST: wr_burst = 1'b1;
        `PD_OFS_DEVINFO: wr_devinfo = 1'b1;
        `PD_OFS_RATE: wr_rate = 1'b1;
        `PD_OFS_EPADDR: wr_epaddr = 1'b1;
        default: wr_stage = 1'b0;
      endcase
    end
  end

  // write answer, a one-cycle pulse per request
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_wr_done <= 1'b0;
      o_wr_reject <= 1'b0;
    end else begin
      o_wr_done <= i_desc_wr && wr_ok;
      o_wr_reject <= i_desc_wr && !wr_ok;
    end
  end

  // shared low-byte stage; a lone high byte reuses a stale low byte
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      lo_stage_ff <= 8'h00;
    end else if (wr_stage) begin
      lo_stage_ff <= i_wr_data;
    end
  end

  // two-byte fields commit whole; a bus reset frees all blocks
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      for (k = 0; k < `NUM_PIPES; k = k + 1) begin
        blocks_ff[k] <= 16'h0000;
        mps_ff[k] <= 16'h0000;
      end
    end else begin
      // [R11] whole count lands at once
      if (wr_blocks) begin
        blocks_ff[i_pipe_sel] <= wr_word;
      end
      // [R12] new packet size limit
      if (wr_mps) begin
        mps_ff[i_pipe_sel] <= wr_word;
      end
    end
  end

  // one-byte fields of the addressed pipe
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      for (j = 0; j < `NUM_PIPES; j = j + 1) begin
        burst_ff[j] <= `BURST_RST;
        devinfo_ff[j] <= 8'h00;
        rate_ff[j] <= 8'h00;
        epnum_ff[j] <= 4'h0;
        epdir_ff[j] <= 1'b0;
      end
    end else begin
      // [R13] only checked values arrive here
      if (wr_burst) begin
        burst_ff[i_pipe_sel] <= i_wr_data;
      end
      // [R14] device info buffer choice
      if (wr_devinfo) begin
        devinfo_ff[i_pipe_sel] <= i_wr_data;
      end
      // [R15] transmit rate code
      if (wr_rate) begin
        rate_ff[i_pipe_sel] <= i_wr_data;
      end
      // [R17] drop reserved bits 6:4
      if (wr_epaddr) begin
        epnum_ff[i_pipe_sel] <= i_wr_data[`EP_NUM_MSB:0];
        epdir_ff[i_pipe_sel] <= i_wr_data[`EP_DIR_BIT];
      end
    end
  end

  // active pipe parameters steer the downstream transfer engine
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_pkt_limit <= 16'h0000;
      o_burst_limit <= `BURST_RST;
      o_devinfo_sel <= 8'h00;
      o_phy_rate <= 8'h00;
      o_ep_num <= 4'h0;
      o_ep_dir_in <= 1'b0;
    end else begin
      // [R12] packet size limit
      o_pkt_limit <= mps_ff[i_active_pipe];
      // [R13] burst limit follows the stored value
      o_burst_limit <= burst_ff[i_active_pipe];
      // [R14] device info buffer choice
      o_devinfo_sel <= devinfo_ff[i_active_pipe];
      // [R15] transmit rate
      o_phy_rate <= rate_ff[i_active_pipe];
      o_ep_num <= epnum_ff[i_active_pipe];
      // [R17] direction ignored on control
      o_ep_dir_in <= epdir_ff[i_active_pipe] && !i_active_is_control;
    end
  end

  // pending notification kinds; a new event beats the ack
  always @* begin
    ntf_events = 3'h0;
    ntf_events[`NTF_DEVICE] = i_dev_notify;
    ntf_events[`NTF_STATUS] = i_status_change;
    ntf_events[`NTF_XFER] = i_xfer_done;
  end

  // set wins: an event in the ack cycle stays pending
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_notify_pending <= 3'h0;
    end else begin
      // [R1] every event is reported
      o_notify_pending <= ntf_events |
                          (o_notify_pending & {3{!i_notify_ack}});
    end
  end

endmodule

/* File: pipe_desc_asserts.sv */
// port assertions for the descriptor store
// assumes one clock and a synchronous active-low reset
module pipe_desc_asserts (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_desc_rd,
  input wire i_desc_wr,
  input wire [1:0] i_desc_sel,
  input wire [4:0] i_byte_offset,
  input wire i_dev_notify,
  input wire i_active_is_control,
  input wire [7:0] o_rd_data,
  input wire o_rd_valid,
  input wire o_wr_done,
  input wire o_wr_reject,
  input wire [2:0] o_notify_pending,
  input wire [7:0] o_burst_limit,
  input wire o_ep_dir_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  wire pipe_rd = i_desc_rd && i_desc_sel == 2'h3;
  wire ep_rd = i_desc_rd && i_desc_sel != 2'h3;
  // every request gets exactly one answer a cycle later
  chk_rd_answer: assert property (i_desc_rd |=> o_rd_valid)
    else $error("read not answered");
  chk_rd_quiet: assert property (!i_desc_rd |=> !o_rd_valid)
    else $error("read valid without request");
  chk_wr_answer: assert property (i_desc_wr |=> o_wr_done ^ o_wr_reject)
    else $error("write answer missing or doubled");
  chk_ro_refused: assert property (
    i_desc_wr && i_byte_offset < 5'h06 |=> o_wr_reject)
    else $error("read-only byte written");
  // fixed bytes of both descriptor kinds
  chk_pipe_len: assert property (
    pipe_rd && i_byte_offset == 5'h00 |=> o_rd_data == 8'h1c)
    else $error("pipe length wrong");
  chk_pipe_type: assert property (
    pipe_rd && i_byte_offset == 5'h01 |=> o_rd_data == 8'h22)
    else $error("pipe type wrong");
  chk_ep_len: assert property (
    ep_rd && i_byte_offset == 5'h00 |=> o_rd_data == 8'h07)
    else $error("endpoint length wrong");
  chk_ntf_ivl: assert property (
    ep_rd && i_desc_sel == 2'h0 && i_byte_offset == 5'h06
    |=> o_rd_data == 8'h01)
    else $error("notify interval wrong");
  chk_burst_range: assert property (
    o_burst_limit >= 8'h01 && o_burst_limit <= 8'h10)
    else $error("burst limit out of range");
  chk_ntf_set: assert property (i_dev_notify |=> o_notify_pending[0])
    else $error("device event not pending");
  chk_dir_masked: assert property (i_active_is_control |=> !o_ep_dir_in)
    else $error("direction not masked");
endmodule

/* File: host_model.sv */
// host side: issues one descriptor byte per request
// assumes the store answers at the taking edge, sampled at the next falling edge
module host_model (
  input wire i_core_clk,
  input wire [7:0] i_rd_data,
  input wire i_rd_valid,
  input wire i_wr_done,
  input wire i_wr_reject,
  output logic o_rd = 1'b0,
  output logic o_wr = 1'b0,
  output logic [1:0] o_sel = 2'h0,
  output logic [1:0] o_pipe = 2'h0,
  output logic [4:0] o_ofs = 5'h00,
  output logic [7:0] o_data = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // pipe descriptors fetched one request at a time
  task automatic xfer(input bit w, input int s, p, f, d,
                      output logic [7:0] q, output logic v);
    @(negedge i_core_clk);
    o_rd = !w;
    o_wr = w;
    o_sel = s[1:0];
    o_pipe = p[1:0];
    o_ofs = f[4:0];
    o_data = d[7:0];
    @(negedge i_core_clk);
    q = w ? {6'h00, i_wr_reject, i_wr_done} : i_rd_data;
    v = w | i_rd_valid;
    o_rd = 1'b0;
    o_wr = 1'b0;
    // released data lines flip so stale values never look valid
    o_data = ~o_data;
  endtask
endmodule

/* File: tb.sv */
// self-checking bench for the descriptor store with a behavioural model
// assumes host_model drives the request port
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
    $display("Error %0t: got %h want %h", $time, a, e); end end
  localparam [15:0] BMPS = 16'h0100;
  localparam [15:0] CAP = 16'h0007;
  logic i_core_clk = 0, i_rst_b = 0, i_active_is_control = 0;
  logic i_dev_notify = 0, i_status_change = 0, i_xfer_done = 0;
  logic i_notify_ack = 0, i_desc_rd, i_desc_wr, o_rd_valid;
  logic o_wr_done, o_wr_reject, o_ep_dir_in;
  logic [1:0] i_desc_sel, i_pipe_sel, i_active_pipe = 2'h0;
  logic [4:0] i_byte_offset;
  logic [7:0] i_wr_data, o_rd_data, o_burst_limit, o_devinfo_sel, o_phy_rate;
  logic [2:0] o_notify_pending;
  logic [15:0] o_pkt_limit;
  logic [3:0] o_ep_num;
  logic [31:0] lfsr = 32'h7c4deddc;
  int errors = 0, n_compared = 0, cyc = 0, m_stage = 0;
  int m_blk[4] = '{default: 0}, m_mps[4] = '{default: 0};
  int m_burst[4] = '{default: 1}, m_dev[4] = '{default: 0};
  int m_rate[4] = '{default: 0}, m_ep[4] = '{default: 0};
  int bursts[4] = '{0, 1, 16, 17};
  pipe_desc_store #(.NOTIFY_EP_ADDR(8'h85), .WRITE_EP_ADDR(8'h06),
    .READ_EP_ADDR(8'h87), .BULK_MPS(BMPS), .PIPE_REQ_CAP(CAP)) dut (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_desc_rd(i_desc_rd),
    .i_desc_wr(i_desc_wr), .i_desc_sel(i_desc_sel), .i_pipe_sel(i_pipe_sel),
    .i_byte_offset(i_byte_offset), .i_wr_data(i_wr_data),
    .i_active_pipe(i_active_pipe), .i_active_is_control(i_active_is_control),
    .i_dev_notify(i_dev_notify), .i_status_change(i_status_change),
    .i_xfer_done(i_xfer_done), .i_notify_ack(i_notify_ack),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_wr_done(o_wr_done),
    .o_wr_reject(o_wr_reject), .o_notify_pending(o_notify_pending),
    .o_pkt_limit(o_pkt_limit), .o_burst_limit(o_burst_limit),
    .o_devinfo_sel(o_devinfo_sel), .o_phy_rate(o_phy_rate),
    .o_ep_num(o_ep_num), .o_ep_dir_in(o_ep_dir_in));
  host_model host (.i_core_clk(i_core_clk), .i_rd_data(o_rd_data),
    .i_rd_valid(o_rd_valid), .i_wr_done(o_wr_done),
    .i_wr_reject(o_wr_reject), .o_rd(i_desc_rd), .o_wr(i_desc_wr),
    .o_sel(i_desc_sel), .o_pipe(i_pipe_sel), .o_ofs(i_byte_offset),
    .o_data(i_wr_data));
  initial forever #2 i_core_clk = ~i_core_clk;
  function automatic int rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  // expected byte, two-byte fields low first
  function automatic int exp_byte(int s, int p, int f);
    int d[15] = '{8'h1c, 8'h22, p, 0, CAP & 255, CAP >> 8, m_blk[p] & 255,
      m_blk[p] >> 8, m_mps[p] & 255, m_mps[p] >> 8, m_burst[p], m_dev[p],
      m_rate[p], 0, m_ep[p]};
    int e[7] = '{8'h07, 8'h05, s == 1 ? 8'h06 : s ? 8'h87 : 8'h85,
      s ? 8'h02 : 8'h03, s ? BMPS & 255 : 8'h40, s ? BMPS >> 8 : 0,
      s ? 0 : 1};
    if (s == 3) return f < 15 ? d[f] : 0;
    return f < 7 ? e[f] : 0;
  endfunction
  // write model: low bytes staged, word committed at the high byte
  function automatic bit wr_ok(int p, int f, int d);
    if (f < 6 || f > 14 || (f == 13 && d != 0)) return 0;
    if ((f == 10 && (d < 1 || d > 16)) || (f == 7 && m_blk[p] != 0)) return 0;
    case (f)
      6, 8: m_stage = d;
      7: m_blk[p] = d << 8 | m_stage;
      9: m_mps[p] = d << 8 | m_stage;
      10: m_burst[p] = d;
      11: m_dev[p] = d;
      12: m_rate[p] = d;
      14: m_ep[p] = d;
    endcase
    return 1;
  endfunction
  task automatic rd(int s, int p, int f);
    logic [7:0] q;
    logic v;
    host.xfer(0, s, p, f, 0, q, v);
    `CHK(v, 1'b1)
    `CHK(q, exp_byte(s, p, f))
  endtask
  task automatic wr(int p, int f, int d);
    logic [7:0] q;
    logic v;
    bit ok = wr_ok(p, f, d);
    host.xfer(1, 3, p, f, d, q, v);
    `CHK(q, ok ? 8'h01 : 8'h02)
  endtask
  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard, twenty thousand cycles is ample
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(negedge i_core_clk);
    i_rst_b = 1;
    for (int p = 0; p < 4; p++)
      for (int s = 0; s < 4; s++)
        for (int f = 0; f < 16; f++) rd(s, p, f);
    for (int p = 0; p < 4; p++) begin
      // random sweep twice: second high byte of blocks must lock
      repeat (2) for (int f = 0; f < 16; f++) wr(p, f, rnd());
      foreach (bursts[i]) wr(p, 10, bursts[i]);
      wr(p, 13, 0);
      wr(p, 14, rnd() & 8'h8f);
      for (int f = 0; f < 16; f++) rd(3, p, f);
      i_active_pipe = p[1:0];
      i_active_is_control = p[0];
      repeat (2) @(negedge i_core_clk);
      `CHK(o_pkt_limit, m_mps[p])
      `CHK(o_burst_limit, m_burst[p])
      `CHK(o_devinfo_sel, m_dev[p])
      `CHK(o_phy_rate, m_rate[p])
      `CHK(o_ep_num, m_ep[p] & 15)
      `CHK(o_ep_dir_in, p[0] ? 0 : m_ep[p] >> 7)
    end
    // each event sets its own sticky bit; ack alongside a set keeps it
    for (int k = 0; k < 3; k++) begin
      {i_xfer_done, i_status_change, i_dev_notify} = 3'h1 << k;
      i_notify_ack = k[0];
      @(negedge i_core_clk);
      {i_xfer_done, i_status_change, i_dev_notify} = 3'h0;
      i_notify_ack = 1;
      `CHK(o_notify_pending, 3'h1 << k)
      @(negedge i_core_clk);
      i_notify_ack = 0;
      `CHK(o_notify_pending, 3'h0)
      // let an edge pass so the ack is not raised again at once
      @(negedge i_core_clk);
    end
    give_verdict();
  end
endmodule
bind pipe_desc_store pipe_desc_asserts u_chk (.i_core_clk(i_core_clk),
  .i_rst_b(i_rst_b), .i_desc_rd(i_desc_rd), .i_desc_wr(i_desc_wr),
  .i_desc_sel(i_desc_sel), .i_byte_offset(i_byte_offset),
  .i_dev_notify(i_dev_notify), .i_active_is_control(i_active_is_control),
  .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_wr_done(o_wr_done),
  .o_wr_reject(o_wr_reject), .o_notify_pending(o_notify_pending),
  .o_burst_limit(o_burst_limit), .o_ep_dir_in(o_ep_dir_in));
